//--- src/idc_pkg.sv
// Package: constants and types for the instruction dispatch classifier
// ============================================================
// Behaviour
// RULE_01: General register operand from specifier bits 5..3
// RULE_02: Media registers: second bits 2..0, first 5..3
// RULE_03: Specifier selects register or memory decode row
// RULE_04: Mode 10b, 01b, 00b memory; 11b register
// RULE_05: Per clock: two short, one long, one vector
// RULE_06: Any two adjacent short instructions pair
// RULE_07: Media instructions short except clear and cache_instr_a
// RULE_08: Loads, stores, branch, float, media to units
// RULE_09: Plain alu either unit; alux only X
// RULE_10: Load immediate stays in control unit
// RULE_11: Two independent chains emitted as two groups; the code sets every group bit to 0
// RULE_12: Add-with-carry encodings use vector path
// RULE_13: ASCII adjust instructions use vector path
// RULE_14: Add memory destination long: load, add, store
// RULE_15: Add into register short; memory adds load
// RULE_16: Register add and accumulator add single op
// RULE_17: Valid, class, ops held while scheduler stalls
// RULE_18: Reset discards partial decode, no valid output
package idc_pkg;

    // ============================================================
    // Decode classes
    typedef enum logic [1:0] {
        IDC_CLS_NONE,
        IDC_CLS_SHORT,
        IDC_CLS_LONG,
        IDC_CLS_VECTOR
    } idc_class_t;

    // Micro-operation kinds
    typedef enum logic [3:0] {
        IDC_OP_NONE, IDC_OP_LOAD, IDC_OP_FLOAD, IDC_OP_MLOAD, IDC_OP_STORE,
        IDC_OP_FSTORE, IDC_OP_MSTORE, IDC_OP_ALU, IDC_OP_ALUX, IDC_OP_BRANCH,
        IDC_OP_FLOAT, IDC_OP_MEU, IDC_OP_LIMM
    } idc_op_t;

    // Execution units a micro-operation is steered to
    typedef enum logic [2:0] {
        IDC_UNIT_NONE, IDC_UNIT_LOAD, IDC_UNIT_STORE, IDC_UNIT_INT_ANY,
        IDC_UNIT_INT_X, IDC_UNIT_BRANCH, IDC_UNIT_FPU, IDC_UNIT_MEDIA
    } idc_unit_t;

    // ============================================================
    // Operand specifier byte fields
    localparam int IDC_MOD_HI = 7;
    localparam int IDC_MOD_LO = 6;
    localparam int IDC_REG_HI = 5;
    localparam int IDC_REG_LO = 3;
    localparam int IDC_RM_HI = 2;
    localparam int IDC_RM_LO = 0;
    localparam logic [1:0] IDC_MOD_REGISTER = 2'h3;
    localparam logic [2:0] IDC_GRP_ADC = 3'h2;
    localparam logic [2:0] IDC_GRP_ADD = 3'h0;

    // ============================================================
    // Opcodes
    localparam logic [7:0] IDC_OPC_ADD_RM8 = 8'h00;
    localparam logic [7:0] IDC_OPC_ADD_RMW = 8'h01;
    localparam logic [7:0] IDC_OPC_ADD_R8 = 8'h02;
    localparam logic [7:0] IDC_OPC_ADD_RW = 8'h03;
    localparam logic [7:0] IDC_OPC_ADD_AL = 8'h04;
    localparam logic [7:0] IDC_OPC_ADC_LO = 8'h10;
    localparam logic [7:0] IDC_OPC_ADC_HI = 8'h15;
    localparam logic [7:0] IDC_OPC_ADJ_ADD = 8'h37;
    localparam logic [7:0] IDC_OPC_ADJ_SUB = 8'h3f;
    localparam logic [7:0] IDC_OPC_ADJ_MUL = 8'hd4;
    localparam logic [7:0] IDC_OPC_ADJ_DIV = 8'hd5;
    localparam logic [7:0] IDC_OPC_ADJ_BASE = 8'h0a;
    localparam logic [7:0] IDC_OPC_GRP_I8 = 8'h80;
    localparam logic [7:0] IDC_OPC_GRP_IW = 8'h81;
    localparam logic [7:0] IDC_OPC_GRP_IS8 = 8'h83;
    localparam logic [7:0] IDC_OPC_ESCAPE = 8'h0f;
    localparam logic [7:0] IDC_OPC_FAST_CLR = 8'h0e;
    localparam logic [7:0] IDC_OPC_CACHE_INSTR_A = 8'h0d;
    localparam logic [7:0] IDC_OPC_STATE_CLR = 8'h77;

    // Micro-operation list length per instruction
    localparam int IDC_MAX_UOPS = 3;
    localparam int IDC_SLOTS = 2;

endpackage : idc_pkg

//--- src/idc_classifier.sv
// Instruction dispatch classifier: two-slot decode of fetched instruction bytes
`timescale 1ns/10ps
`default_nettype none

module idc_classifier
    import idc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Fetch side: two adjacent instructions, three bytes each
    input wire logic [IDC_SLOTS-1:0] i_ins_valid,
    input wire logic [IDC_SLOTS-1:0][7:0] i_opc0,
    input wire logic [IDC_SLOTS-1:0][7:0] i_opc1,
    input wire logic [IDC_SLOTS-1:0][7:0] i_operand_specifier_byte,
    input wire logic [IDC_SLOTS-1:0] i_is_media,
    output logic [1:0] o_ins_taken,
    // Scheduler side
    input wire logic i_sched_ready,
    output logic [IDC_SLOTS-1:0] o_out_valid,
    output idc_class_t [IDC_SLOTS-1:0] o_class,
    output idc_op_t [IDC_SLOTS-1:0][IDC_MAX_UOPS-1:0] o_uop,
    output idc_unit_t [IDC_SLOTS-1:0][IDC_MAX_UOPS-1:0] o_unit,
    output logic [IDC_SLOTS-1:0][IDC_MAX_UOPS-1:0] o_uop_group,
    output logic [IDC_SLOTS-1:0] o_memory_form,
    output logic [IDC_SLOTS-1:0][2:0] o_word_register_operand,
    output logic [IDC_SLOTS-1:0][2:0] o_first_media_register,
    output logic [IDC_SLOTS-1:0][2:0] o_second_media_register
);

    // ============================================================
    // Reset synchroniser
    logic rst_meta_n;
    logic rst_n;

    // Released through two flops so every process leaves reset together
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ============================================================
    // Per-slot classification
    idc_class_t cls [IDC_SLOTS];
    idc_op_t uop [IDC_SLOTS][IDC_MAX_UOPS];
    logic [IDC_MAX_UOPS-1:0] grp [IDC_SLOTS];
    logic mem_form [IDC_SLOTS];

    // Map each micro-operation kind to its execution unit
    function automatic idc_unit_t unit_of(input idc_op_t op);
        unique case (op)
            IDC_OP_LOAD, IDC_OP_FLOAD, IDC_OP_MLOAD: unit_of = IDC_UNIT_LOAD; // RULE_08
            IDC_OP_STORE, IDC_OP_FSTORE, IDC_OP_MSTORE: unit_of = IDC_UNIT_STORE; // RULE_08
            IDC_OP_ALU: unit_of = IDC_UNIT_INT_ANY; // RULE_09
            IDC_OP_ALUX: unit_of = IDC_UNIT_INT_X; // RULE_09
            IDC_OP_BRANCH: unit_of = IDC_UNIT_BRANCH; // RULE_08
            IDC_OP_FLOAT: unit_of = IDC_UNIT_FPU; // RULE_08
            IDC_OP_MEU: unit_of = IDC_UNIT_MEDIA; // RULE_08
            IDC_OP_LIMM: unit_of = IDC_UNIT_NONE; // RULE_10
            default: unit_of = IDC_UNIT_NONE;
        endcase
    endfunction : unit_of

    genvar s;
    generate
        for (s = 0; s < IDC_SLOTS; s++) begin : g_slot
            wire logic [7:0] op0 = i_opc0[s];
            wire logic [7:0] op1 = i_opc1[s];
            wire logic [7:0] spec = i_operand_specifier_byte[s];
            wire logic [2:0] grp_field = spec[IDC_REG_HI:IDC_REG_LO];
            // Mode 11 is register form, anything else is memory form
            wire logic is_mem = spec[IDC_MOD_HI:IDC_MOD_LO] != IDC_MOD_REGISTER; // RULE_04
            wire logic is_grp = (op0 == IDC_OPC_GRP_I8) || (op0 == IDC_OPC_GRP_IW)
                || (op0 == IDC_OPC_GRP_IS8);
            wire logic is_adc = ((op0 >= IDC_OPC_ADC_LO) && (op0 <= IDC_OPC_ADC_HI))
                || (is_grp && grp_field == IDC_GRP_ADC); // RULE_12
            wire logic is_adjust = (op0 == IDC_OPC_ADJ_ADD) || (op0 == IDC_OPC_ADJ_SUB)
                || (((op0 == IDC_OPC_ADJ_MUL) || (op0 == IDC_OPC_ADJ_DIV))
                && (op1 == IDC_OPC_ADJ_BASE)); // RULE_13
            wire logic is_mem_dst = (op0 == IDC_OPC_ADD_RM8) || (op0 == IDC_OPC_ADD_RMW);
            wire logic is_reg_dst = (op0 == IDC_OPC_ADD_R8) || (op0 == IDC_OPC_ADD_RW);
            wire logic is_acc = op0 == IDC_OPC_ADD_AL;
            // Immediate group forms 80h and 83h also run on the X unit only
            wire logic byte_size = (op0 == IDC_OPC_ADD_RM8) || (op0 == IDC_OPC_ADD_R8)
                || is_acc || (op0 == IDC_OPC_GRP_I8) || (op0 == IDC_OPC_GRP_IS8);
            wire idc_op_t add_op = byte_size ? IDC_OP_ALUX : IDC_OP_ALU; // RULE_09
            // Media long-path members: state clear, fast clear, cache_instr_a
            wire logic media_long = (op0 == IDC_OPC_ESCAPE) && ((op1 == IDC_OPC_STATE_CLR)
                || (op1 == IDC_OPC_FAST_CLR) || (op1 == IDC_OPC_CACHE_INSTR_A)); // RULE_07

            // Choose class and micro-operation row from opcode and specifier
            always_comb begin
                cls[s] = IDC_CLS_VECTOR;
                uop[s][0] = IDC_OP_NONE;
                uop[s][1] = IDC_OP_NONE;
                uop[s][2] = IDC_OP_NONE;
                grp[s] = '0; // RULE_11
                mem_form[s] = is_mem; // RULE_03
                if (is_adc || is_adjust) begin
                    cls[s] = IDC_CLS_VECTOR; // RULE_12 RULE_13
                end else if (i_is_media[s]) begin
                    cls[s] = media_long ? IDC_CLS_LONG : IDC_CLS_SHORT; // RULE_07
                    uop[s][0] = media_long ? IDC_OP_NONE : IDC_OP_MEU; // RULE_08
                end else if (is_mem_dst && is_mem) begin
                    cls[s] = IDC_CLS_LONG; // RULE_14
                    uop[s][0] = IDC_OP_LOAD;
                    uop[s][1] = add_op;
                    uop[s][2] = IDC_OP_STORE;
                end else if (is_reg_dst) begin
                    cls[s] = IDC_CLS_SHORT; // RULE_15
                    uop[s][0] = is_mem ? IDC_OP_LOAD : add_op;
                    uop[s][1] = is_mem ? add_op : IDC_OP_NONE;
                end else if (is_mem_dst || is_acc) begin
                    cls[s] = IDC_CLS_SHORT; // RULE_16
                    uop[s][0] = add_op;
                end else if (is_grp && grp_field == IDC_GRP_ADD) begin
                    cls[s] = is_mem ? IDC_CLS_LONG : IDC_CLS_SHORT;
                    uop[s][0] = is_mem ? IDC_OP_LOAD : add_op;
                    uop[s][1] = is_mem ? add_op : IDC_OP_NONE;
                    uop[s][2] = is_mem ? IDC_OP_STORE : IDC_OP_NONE;
                end
            end
        end
    endgenerate

    // ============================================================
    // Decode-rate limit: pair only two shorts, else one instruction
    wire logic take0 = i_ins_valid[0];
    wire logic pair_ok = i_ins_valid[1] && (cls[0] == IDC_CLS_SHORT)
        && (cls[1] == IDC_CLS_SHORT); // RULE_05 RULE_06
    wire logic advance = i_sched_ready || (o_out_valid == '0); // RULE_17
    wire logic [IDC_SLOTS-1:0] next_valid = {take0 && pair_ok, take0}; // RULE_05

    // Fetch buffer sees how many instructions were consumed this cycle
    assign o_ins_taken = (advance && rst_n) ? {1'b0, take0} + {1'b0, next_valid[1]} : 2'h0;

    // ============================================================
    // Output register, held while the scheduler stalls
    integer k;
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_out_valid <= '0; // RULE_18
            o_class <= '{default: IDC_CLS_NONE};
            o_uop <= '{default: IDC_OP_NONE};
            o_unit <= '{default: IDC_UNIT_NONE};
            o_uop_group <= '0;
            o_memory_form <= '0;
            o_word_register_operand <= '0;
            o_first_media_register <= '0;
            o_second_media_register <= '0;
        end else if (advance) begin
            o_out_valid <= next_valid; // RULE_17
            for (k = 0; k < IDC_SLOTS; k++) begin
                o_class[k] <= next_valid[k] ? cls[k] : IDC_CLS_NONE;
                o_memory_form[k] <= mem_form[k];
                o_uop_group[k] <= grp[k]; // RULE_11
                o_word_register_operand[k] <=
                    i_operand_specifier_byte[k][IDC_REG_HI:IDC_REG_LO]; // RULE_01
                o_first_media_register[k] <=
                    i_operand_specifier_byte[k][IDC_REG_HI:IDC_REG_LO]; // RULE_02
                o_second_media_register[k] <=
                    i_operand_specifier_byte[k][IDC_RM_HI:IDC_RM_LO]; // RULE_02
                for (int u = 0; u < IDC_MAX_UOPS; u++) begin
                    o_uop[k][u] <= uop[k][u];
                    o_unit[k][u] <= unit_of(uop[k][u]); // RULE_08
                end
            end
        end
    end

endmodule : idc_classifier
`default_nettype wire

//--- testbench/idc_classifier_assertions.sv
// Checker: port-level properties of the instruction dispatch classifier
`timescale 1ns/10ps
`default_nettype none
module idc_classifier_assertions
    import idc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [IDC_SLOTS-1:0][7:0] i_opc0,
    input wire logic [IDC_SLOTS-1:0][7:0] i_operand_specifier_byte,
    input wire logic [1:0] o_ins_taken,
    input wire logic i_sched_ready,
    input wire logic [IDC_SLOTS-1:0] o_out_valid,
    input wire idc_class_t [IDC_SLOTS-1:0] o_class,
    input wire idc_op_t [IDC_SLOTS-1:0][IDC_MAX_UOPS-1:0] o_uop,
    input wire idc_unit_t [IDC_SLOTS-1:0][IDC_MAX_UOPS-1:0] o_unit,
    input wire logic [IDC_SLOTS-1:0] o_memory_form,
    input wire logic [IDC_SLOTS-1:0][2:0] o_word_register_operand,
    input wire logic [IDC_SLOTS-1:0][2:0] o_first_media_register,
    input wire logic [IDC_SLOTS-1:0][2:0] o_second_media_register
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // Slot 0 request, looked at only on edges where it is consumed
    wire logic tk = (o_ins_taken != 2'h0);
    wire logic [7:0] op = i_opc0[0];
    wire logic [7:0] sp = i_operand_specifier_byte[0];
    // ============================================================
    // Properties
    chk_reg_field: assert property (tk |=> o_word_register_operand[0] == $past(sp[5:3]))
        else $error("register operand field wrong");
    chk_media_regs: assert property (tk |=> o_first_media_register[0] == $past(sp[5:3])
        && o_second_media_register[0] == $past(sp[2:0]))
        else $error("media register fields wrong");
    chk_mem_form: assert property (tk |=> o_memory_form[0] == ($past(sp[7:6]) != 2'h3))
        else $error("memory form flag wrong");
    chk_adc_vector: assert property (tk && op >= 8'h10 && op <= 8'h15 |=> o_class[0] == IDC_CLS_VECTOR)
        else $error("carry add not vector class");
    chk_adj_vector: assert property (tk && (op == 8'h37 || op == 8'h3f) |=> o_class[0] == IDC_CLS_VECTOR)
        else $error("ascii adjust not vector class");
    chk_pair_short: assert property (o_ins_taken == 2'h2 |=> o_class == {IDC_CLS_SHORT, IDC_CLS_SHORT})
        else $error("paired slots not both short");
    chk_mem_dest: assert property (tk && op <= 8'h01 && sp[7:6] != 2'h3 |=> o_class[0] == IDC_CLS_LONG)
        else $error("memory destination add not long");
    chk_hold_stall: assert property (o_out_valid != 2'h0 && !i_sched_ready |=> $stable(o_out_valid)
        && $stable(o_class) && $stable(o_uop))
        else $error("output changed during stall");
    chk_alux_unit: assert property (o_out_valid[0] |-> (o_uop[0][0] != IDC_OP_ALUX || o_unit[0][0] == IDC_UNIT_INT_X)
        && (o_uop[0][1] != IDC_OP_ALUX || o_unit[0][1] == IDC_UNIT_INT_X))
        else $error("x-only operation steered elsewhere");
    chk_reset_quiet: assert property ($rose(i_rst_n) |-> (o_out_valid == 2'h0) [*2])
        else $error("valid output right after reset");
    // Main scenarios reached
    cover property (o_ins_taken == 2'h2);
    cover property (o_out_valid[0] && !i_sched_ready);
    cover property (o_out_valid[0] && o_class[0] == IDC_CLS_VECTOR);
endmodule : idc_classifier_assertions

bind idc_classifier idc_classifier_assertions idc_classifier_assertions_i (.i_sys_clk, .i_rst_n,
    .i_opc0, .i_operand_specifier_byte, .o_ins_taken, .i_sched_ready, .o_out_valid, .o_class,
    .o_uop, .o_unit, .o_memory_form, .o_word_register_operand, .o_first_media_register,
    .o_second_media_register);
`default_nettype wire

//--- testbench/idc_sched_model.sv
// Partner: scheduler acceptance model on the classifier's output side
`timescale 1ns/10ps
`default_nettype none
module idc_sched_model (
    input wire logic i_sys_clk,
    input wire logic i_stall,
    output logic o_ready
);
    // Registered like a queue-full flag, so a stall lands one edge late
    always_ff @(posedge i_sys_clk) begin
        o_ready <= !i_stall;
    end
endmodule : idc_sched_model
`default_nettype wire

//--- testbench/testbench.sv
// Testbench: directed scenarios for the instruction dispatch classifier
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import idc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic stall = 1'b0;
    logic ready;
    logic [1:0] vld = 2'h0;
    logic [1:0] med = 2'h0;
    logic [1:0][7:0] op0 = 16'h0, op1 = 16'h0, spec = 16'h0;
    logic [1:0] taken, tk, ovld, memf;
    idc_class_t [1:0] cls;
    idc_op_t [1:0][2:0] uop;
    idc_unit_t [1:0][2:0] unit;
    logic [1:0][2:0] grp, wreg, freg, sreg;
    int error_cnt = 0;
    int cmp_count = 0;
    // Opcode, second byte and specifier of every carry-add and ASCII adjust encoding
    logic [23:0] vt [13] = '{24'h1000c0, 24'h1100c0, 24'h1200c0, 24'h130005, 24'h1400c0,
        24'h1500c0, 24'h8000d0, 24'h810050, 24'h8300d0, 24'h370000, 24'h3f0000, 24'hd50a00,
        24'hd40a00};

    initial begin
        forever #10 clk = ~clk;
    end

    idc_sched_model idc_sched_model_i (.i_sys_clk(clk), .i_stall(stall), .o_ready(ready));
    idc_classifier idc_classifier_i (.i_sys_clk(clk), .i_rst_n(rst_n), .i_ins_valid(vld),
        .i_opc0(op0), .i_opc1(op1), .i_operand_specifier_byte(spec), .i_is_media(med),
        .o_ins_taken(taken), .i_sched_ready(ready), .o_out_valid(ovld), .o_class(cls),
        .o_uop(uop), .o_unit(unit), .o_uop_group(grp), .o_memory_form(memf),
        .o_word_register_operand(wreg), .o_first_media_register(freg),
        .o_second_media_register(sreg));

    // ============================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One request for a single edge; both slots carry the same bytes
    task automatic issue(input logic [7:0] a, input logic [7:0] b, input logic [7:0] s,
        input logic m, input logic two);
        @(posedge clk);
        vld <= {two, 1'b1};
        op0 <= {a, a};
        op1 <= {b, b};
        spec <= {s, s};
        med <= {m, m};
        @(negedge clk);
        tk = taken;
        @(posedge clk);
        vld <= 2'h0;
        @(negedge clk);
    endtask : issue

    task automatic wrap_up;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    // ============================================================
    // Scenarios
    task automatic t_pair_add;
        issue(IDC_OPC_ADD_RW, 8'h00, 8'hd1, 1'b0, 1'b1);
        chk("taken", 4'h2, tk);
        chk("class1", IDC_CLS_SHORT, cls[1]);
        chk("uop", IDC_OP_ALU, uop[0][0]);
        chk("unit", IDC_UNIT_INT_ANY, unit[0][0]);
        chk("wreg", 4'h2, wreg[0]);
        chk("freg", 4'h2, freg[0]);
        chk("sreg", 4'h1, sreg[0]);
        chk("memf", 4'h0, memf[0]);
        chk("group", 4'h0, grp[0]);
    endtask : t_pair_add

    // Each memory mode value with a second copy of the same long instruction behind it
    task automatic t_mem_dest;
        for (int i = 0; i < 3; i++) begin
            issue(8'(i % 2), 8'h00, 8'h05 | 8'(i << 6), 1'b0, 1'b1);
            chk("taken", 4'h1, tk);
            chk("class", IDC_CLS_LONG, cls[0]);
            chk("uop0", IDC_OP_LOAD, uop[0][0]);
            chk("uop1", (i % 2) ? IDC_OP_ALU : IDC_OP_ALUX, uop[0][1]);
            chk("unit2", IDC_UNIT_STORE, unit[0][2]);
            chk("memf", 4'h1, memf[0]);
        end
    endtask : t_mem_dest

    task automatic t_short_add;
        issue(IDC_OPC_ADD_R8, 8'h00, 8'h05, 1'b0, 1'b0);
        chk("class", IDC_CLS_SHORT, cls[0]);
        chk("unit0", IDC_UNIT_LOAD, unit[0][0]);
        chk("unit1", IDC_UNIT_INT_X, unit[0][1]);
        issue(IDC_OPC_ADD_AL, 8'h00, 8'hc0, 1'b0, 1'b0);
        chk("uop", IDC_OP_ALUX, uop[0][0]);
        chk("uop1", IDC_OP_NONE, uop[0][1]);
        issue(IDC_OPC_GRP_I8, 8'h00, 8'hc0, 1'b0, 1'b0);
        chk("grp_unit", IDC_UNIT_INT_X, unit[0][0]);
    endtask : t_short_add

    task automatic t_vector;
        foreach (vt[i]) begin
            issue(vt[i][23:16], vt[i][15:8], vt[i][7:0], 1'b0, 1'b1);
            chk("taken", 4'h1, tk);
            chk("class", IDC_CLS_VECTOR, cls[0]);
        end
    endtask : t_vector

    task automatic t_media;
        logic [7:0] codes [3] = '{8'h77, 8'h0e, 8'h0d};
        foreach (codes[i]) begin
            issue(8'h0f, codes[i], 8'hc0, 1'b1, 1'b0);
            chk("class", IDC_CLS_LONG, cls[0]);
        end
        issue(8'h0f, 8'hfc, 8'hc1, 1'b1, 1'b1);
        chk("taken", 4'h2, tk);
    endtask : t_media

    // Output taken while nothing is pending, then held and refusing more
    task automatic t_stall;
        stall <= 1'b1;
        issue(IDC_OPC_ADD_RW, 8'h00, 8'hd1, 1'b0, 1'b0);
        issue(8'h37, 8'h00, 8'h00, 1'b0, 1'b0);
        chk("refused", 4'h0, tk);
        chk("held", 4'h1, ovld);
        chk("class", IDC_CLS_SHORT, cls[0]);
        stall <= 1'b0;
        repeat (3) @(negedge clk);
        chk("drain", 4'h0, ovld);
    endtask : t_stall

    task automatic t_reset;
        @(posedge clk);
        vld <= 2'h1;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        vld <= 2'h0;
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            chk("quiet", 4'h0, ovld);
        end
    endtask : t_reset

    // Watchdog: the whole sequence needs about 70 cycles
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_pair_add();
        t_mem_dest();
        t_short_add();
        t_vector();
        t_media();
        t_stall();
        t_reset();
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
